/* common/cspr_pkg.sv */
// ============================================================
// Notes on behaviour
// - three-bit mode field picks multi-phase or multiple-output, master or slave
// - one master sets switching frequency; in multi-phase it also supplies error
// - multi-phase master drives switching clock and error amplifier onto pins
// - multi-phase slave takes clock pin as input and locks to it
// - any slave offsets its switching clock by the programmed phase shift
// - multi-phase slave regulates from the pin error signal, not own amplifier
// - multi-phase slave applies the programmed slave gain to incoming error
// - multiple-output master drives its switching clock onto the clock pin
// - multiple-output slave takes clock pin as input and syncs to it
package cspr_pkg;

  // ============================================================
  // mode field codes
  localparam logic [2:0] CSPR_MODE_GPIO = 3'h0;
  localparam logic [2:0] CSPR_MODE_MP_MASTER = 3'h1;
  localparam logic [2:0] CSPR_MODE_MP_SLAVE = 3'h2;
  localparam logic [2:0] CSPR_MODE_MO_MASTER = 3'h3;
  localparam logic [2:0] CSPR_MODE_MO_SLAVE = 3'h4;

  // ============================================================
  // widths and reset values
  localparam int CSPR_ERR_W = 8;
  localparam int CSPR_PER_W = 16;
  localparam int CSPR_GAIN_W = 3;
  localparam int CSPR_GAIN_FRAC = 3;
  localparam logic [CSPR_PER_W-1:0] CSPR_CNT_RST = 16'h0000;

  typedef enum {CSPR_ROLE_GPIO, CSPR_ROLE_MPM, CSPR_ROLE_MPS,
    CSPR_ROLE_MOM, CSPR_ROLE_MOS} cspr_role_t;

  // unknown codes fall back to plain pins
  function automatic cspr_role_t cspr_decode(input logic [2:0] mode);
    cspr_role_t r;
    r = CSPR_ROLE_GPIO;
    if (mode == CSPR_MODE_MP_MASTER) r = CSPR_ROLE_MPM;
    if (mode == CSPR_MODE_MP_SLAVE) r = CSPR_ROLE_MPS;
    if (mode == CSPR_MODE_MO_MASTER) r = CSPR_ROLE_MOM;
    if (mode == CSPR_MODE_MO_SLAVE) r = CSPR_ROLE_MOS;
    return r;
  endfunction

endpackage

/* design/cspr_link_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module cspr_link_pins
(
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic sync_clock_pin_in,
  input wire logic drive_level_in,
  input wire logic drive_en_in,
  output logic sync_clock_pin_out,
  output logic sync_clock_pin_oe_out,
  output logic edge_tgl_out
);
  logic rst_meta_reg, link_rst_reg;
  logic pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_stable_reg;
  logic lvl_meta_reg, en_meta_reg;

  // ============================================================
  // reset brought into the link domain
  always_ff @(posedge link_clk_in)
  begin
    rst_meta_reg <= rst_in;
    link_rst_reg <= rst_meta_reg;
  end

  // three-stage pin sampler; a level counts once stages two and three agree
  always_ff @(posedge link_clk_in)
  begin
    pin_s1_reg <= sync_clock_pin_in;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
  end

  // each accepted rising edge of the master clock flips the toggle
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_reg)
    begin
      pin_stable_reg <= 1'b0;
      edge_tgl_out <= 1'b0;
    end
    else if (pin_s2_reg == pin_s3_reg)
    begin
      pin_stable_reg <= pin_s3_reg;
      if (pin_s3_reg && !pin_stable_reg) edge_tgl_out <= !edge_tgl_out;
    end
  end

  // drive level and enable are single-bit levels from the core, two flops
  always_ff @(posedge link_clk_in)
  begin
    lvl_meta_reg <= drive_level_in;
    en_meta_reg <= drive_en_in;
    if (link_rst_reg)
    begin
      sync_clock_pin_out <= 1'b0;
      sync_clock_pin_oe_out <= 1'b0;
    end
    else
    begin
      sync_clock_pin_out <= lvl_meta_reg;
      sync_clock_pin_oe_out <= en_meta_reg;
    end
  end
endmodule // cspr_link_pins
`default_nettype wire

/* design/cspr_sw_clock_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module cspr_sw_clock_gen
  import cspr_pkg::*;
#(
  parameter int PER_W = CSPR_PER_W
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic slave_in,
  input wire logic [PER_W-1:0] period_in,
  input wire logic [PER_W-1:0] phase_in,
  input wire logic master_edge_in,
  output logic sw_clk_out,
  output logic restart_out,
  output logic locked_out
);
  logic [PER_W-1:0] cnt_reg, cnt_next, meas_reg, mper_reg, dly_reg, per;
  logic armed_reg;

  // slave follows the measured master period, otherwise its own setting
  assign per = slave_in ? mper_reg : period_in;
  assign restart_out = slave_in && armed_reg && (dly_reg == '0);

  // ============================================================
  // master period measured in core cycles between accepted edges
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !slave_in)
    begin
      meas_reg <= CSPR_CNT_RST;
      mper_reg <= CSPR_CNT_RST;
    end
    else if (master_edge_in)
    begin
      mper_reg <= PER_W'(meas_reg + 1'b1);
      meas_reg <= CSPR_CNT_RST;
    end
    else
      meas_reg <= PER_W'(meas_reg + 1'b1);
  end

  // phase delay: restart lands phase_in+1 cycles after the edge pulse
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !slave_in)
    begin
      armed_reg <= 1'b0;
      dly_reg <= CSPR_CNT_RST;
    end
    else if (master_edge_in)
    begin
      armed_reg <= 1'b1;
      dly_reg <= phase_in;
    end
    else if (armed_reg)
    begin
      if (dly_reg == '0) armed_reg <= 1'b0;
      else dly_reg <= PER_W'(dly_reg - 1'b1);
    end
  end

  // period counter; a restart realigns it, which is the lock
  always_comb
  begin
    if (restart_out) cnt_next = CSPR_CNT_RST;
    else if (cnt_reg >= PER_W'(per - 1'b1)) cnt_next = CSPR_CNT_RST;
    else cnt_next = PER_W'(cnt_reg + 1'b1);
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= CSPR_CNT_RST;
      sw_clk_out <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      sw_clk_out <= cnt_next < (per >> 1);
    end
  end

  // lock flag shows a realignment on a measured period
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !slave_in) locked_out <= 1'b0;
    else if (restart_out && mper_reg != '0) locked_out <= 1'b1;
  end
endmodule // cspr_sw_clock_gen
`default_nettype wire

/* design/cspr_pin_routing.sv */
`timescale 1ns/1ps
`default_nettype none
module cspr_pin_routing
  import cspr_pkg::*;
#(
  parameter int ERR_W = CSPR_ERR_W,
  parameter int PER_W = CSPR_PER_W
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic [2:0] multiphase_mode_field_in,
  input wire logic [PER_W-1:0] phase_shift_in,
  input wire logic [cspr_pkg::CSPR_GAIN_W-1:0] slave_gain_in,
  input wire logic [PER_W-1:0] period_in,
  input wire logic [ERR_W-1:0] error_amp_in,
  input wire logic gpio_sync_out_in,
  input wire logic gpio_sync_oe_in,
  input wire logic [ERR_W-1:0] gpio_err_out_in,
  input wire logic gpio_err_oe_in,
  input wire logic sync_clock_pin_in,
  output logic sync_clock_pin_out,
  output logic sync_clock_pin_oe_out,
  input wire logic [ERR_W-1:0] error_signal_pin_in,
  output logic [ERR_W-1:0] error_signal_pin_out,
  output logic error_signal_pin_oe_out,
  output logic [ERR_W-1:0] error_pin_value_out,
  output logic [ERR_W-1:0] regulate_error_out,
  output logic sw_clk_out,
  output logic locked_out
);
  import cspr_pkg::*;

  cspr_role_t role_reg;
  logic is_master, is_slave, mp_master, mp_slave;
  logic drive_level_reg, drive_en_reg;
  logic edge_tgl, tgl_meta_reg, tgl_sync_reg, tgl_prev_reg, master_edge;
  logic [ERR_W-1:0] err_s1_reg, err_s2_reg, err_s3_reg, err_word_reg;
  logic restart, sw_clk;

  // ============================================================
  // slave gain: word times (8+code)/8, saturated at full scale
  function automatic logic [ERR_W-1:0] cspr_gain(
    input logic [ERR_W-1:0] w,
    input logic [CSPR_GAIN_W-1:0] g);
    logic [ERR_W+CSPR_GAIN_W+1:0] p;
    p = (ERR_W+CSPR_GAIN_W+2)'(w) *
      (ERR_W+CSPR_GAIN_W+2)'({1'b1, g});
    p = p >> CSPR_GAIN_FRAC;
    if (p > (ERR_W+CSPR_GAIN_W+2)'({ERR_W{1'b1}}))
      return {ERR_W{1'b1}};
    return p[ERR_W-1:0];
  endfunction

  // ============================================================
  // mode decode
  // registered so a firmware write settles before any pin turns round
  always_ff @(posedge clock_in)
  begin
    if (rst_in) role_reg <= CSPR_ROLE_GPIO;
    else role_reg <= cspr_decode(multiphase_mode_field_in);
  end

  assign mp_master = (role_reg == CSPR_ROLE_MPM);
  assign mp_slave = (role_reg == CSPR_ROLE_MPS);
  assign is_master = mp_master || (role_reg == CSPR_ROLE_MOM);
  assign is_slave = mp_slave || (role_reg == CSPR_ROLE_MOS);

  // ============================================================
  // clock pin: a master shows its switching clock, a slave listens
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      drive_level_reg <= 1'b0;
      drive_en_reg <= 1'b0;
    end
    else
    begin
      unique case (role_reg)
        CSPR_ROLE_MPM, CSPR_ROLE_MOM:
        begin
          drive_level_reg <= sw_clk;
          drive_en_reg <= 1'b1;
        end
        CSPR_ROLE_MPS, CSPR_ROLE_MOS:
        begin
          drive_level_reg <= 1'b0;
          drive_en_reg <= 1'b0;
        end
        CSPR_ROLE_GPIO:
        begin
          drive_level_reg <= gpio_sync_out_in;
          drive_en_reg <= gpio_sync_oe_in;
        end
      endcase
    end
  end

  cspr_link_pins u_link
  (
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .sync_clock_pin_in(sync_clock_pin_in),
    .drive_level_in(drive_level_reg),
    .drive_en_in(drive_en_reg),
    .sync_clock_pin_out(sync_clock_pin_out),
    .sync_clock_pin_oe_out(sync_clock_pin_oe_out),
    .edge_tgl_out(edge_tgl)
  );

  // ============================================================
  // master edge toggle crosses on two flops, edge found after them
  always_ff @(posedge clock_in)
  begin
    tgl_meta_reg <= edge_tgl;
    tgl_sync_reg <= tgl_meta_reg;
    if (rst_in) tgl_prev_reg <= 1'b0;
    else tgl_prev_reg <= tgl_sync_reg;
  end

  // edges outside slave roles are ignored, not queued
  assign master_edge = is_slave && (tgl_sync_reg != tgl_prev_reg);

  cspr_sw_clock_gen #(.PER_W(PER_W)) u_gen
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .slave_in(is_slave),
    .period_in(period_in),
    .phase_in(phase_shift_in),
    .master_edge_in(master_edge),
    .sw_clk_out(sw_clk),
    .restart_out(restart),
    .locked_out(locked_out)
  );

  assign sw_clk_out = sw_clk;

  // ============================================================
  // error pin sampler: a new word counts once stages two and three agree
  // the word may be in mid-change at the pin, so only a settled one passes
  always_ff @(posedge clock_in)
  begin
    err_s1_reg <= error_signal_pin_in;
    err_s2_reg <= err_s1_reg;
    err_s3_reg <= err_s2_reg;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in) err_word_reg <= '0;
    else if (err_s2_reg == err_s3_reg) err_word_reg <= err_s3_reg;
  end

  assign error_pin_value_out = err_word_reg;

  // error pin drive: multi-phase master shows its amplifier, multi-phase slave takes the pin
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      error_signal_pin_out <= '0;
      error_signal_pin_oe_out <= 1'b0;
    end
    else if (mp_master)
    begin
      error_signal_pin_out <= error_amp_in;
      error_signal_pin_oe_out <= 1'b1;
    end
    else if (mp_slave)
    begin
      error_signal_pin_out <= '0;
      error_signal_pin_oe_out <= 1'b0;
    end
    else
    begin
      error_signal_pin_out <= gpio_err_out_in;
      error_signal_pin_oe_out <= gpio_err_oe_in;
    end
  end

  // regulation error: a multi-phase slave uses the master's, with gain
  always_ff @(posedge clock_in)
  begin
    if (rst_in) regulate_error_out <= '0;
    else if (mp_slave)
      regulate_error_out <= cspr_gain(err_word_reg, slave_gain_in);
    else regulate_error_out <= error_amp_in;
  end

  // ============================================================
  // helper counters watched only by the checks below
  logic [PER_W-1:0] since_edge_reg, rise_gap_reg;
  logic gap_valid_reg;

  always_ff @(posedge clock_in)
  begin
    if (rst_in || master_edge) since_edge_reg <= '0;
    else since_edge_reg <= PER_W'(since_edge_reg + 1'b1);
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in || !is_master || $changed(period_in))
    begin
      rise_gap_reg <= '0;
      gap_valid_reg <= 1'b0;
    end
    else if ($rose(sw_clk))
    begin
      rise_gap_reg <= PER_W'(1);
      gap_valid_reg <= 1'b1;
    end
    else rise_gap_reg <= PER_W'(rise_gap_reg + 1'b1);
  end

  // ============================================================
  // checks
  a_mode_decode: assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 (multiphase_mode_field_in == CSPR_MODE_MP_SLAVE) |=> mp_slave)
    else $error("mode field not decoded to multi-phase slave");

  a_one_master: assert property (@(posedge clock_in) disable iff (rst_in)
    !(is_master && is_slave) && !(mp_master && locked_out))
    else $error("master and slave roles overlap");

  a_mp_master_err: assert property (@(posedge clock_in) disable iff (rst_in)
    mp_master ##1 mp_master |->
      error_signal_pin_oe_out && error_signal_pin_out == $past(error_amp_in))
    else $error("master error amplifier not on error pin");

  a_master_clk_pin: assert property (@(posedge link_clk_in)
    disable iff (rst_in)
    (is_master && drive_en_reg)[*8] |-> sync_clock_pin_oe_out)
    else $error("master does not drive clock pin");

  a_slave_clk_in: assert property (@(posedge link_clk_in)
    disable iff (rst_in)
    (is_slave && !drive_en_reg)[*4] |-> !sync_clock_pin_oe_out)
    else $error("slave drives clock pin");

  a_phase_shift: assert property (@(posedge clock_in) disable iff (rst_in)
    restart && $stable(phase_shift_in) |->
      since_edge_reg == phase_shift_in)
    else $error("slave restart not at phase shift");

  // a role change away from slave cancels the pending realignment
  a_edge_restart: assert property (@(posedge clock_in) disable iff (rst_in)
    master_edge && phase_shift_in < PER_W'(900) |=>
      ##[0:900] (restart || !is_slave))
    else $error("slave does not realign to master");

  a_slave_err_in: assert property (@(posedge clock_in) disable iff (rst_in)
    mp_slave ##1 mp_slave |-> !error_signal_pin_oe_out &&
      regulate_error_out == cspr_gain($past(err_word_reg),
        $past(slave_gain_in)))
    else $error("slave not regulating from gained pin error");

  a_own_err: assert property (@(posedge clock_in) disable iff (rst_in)
    !mp_slave ##1 !mp_slave |-> regulate_error_out == $past(error_amp_in))
    else $error("own amplifier not used outside slave role");

  a_gain_unity: assert property (@(posedge clock_in) disable iff (rst_in)
    mp_slave && slave_gain_in == '0 ##1 mp_slave |->
      regulate_error_out == $past(err_word_reg))
    else $error("zero gain code does not pass error unchanged");

  a_gpio_pins: assert property (@(posedge clock_in) disable iff (rst_in)
    role_reg == CSPR_ROLE_GPIO ##1 role_reg == CSPR_ROLE_GPIO |->
      error_signal_pin_oe_out == $past(gpio_err_oe_in) &&
      error_signal_pin_out == $past(gpio_err_out_in) &&
      drive_en_reg == $past(gpio_sync_oe_in))
    else $error("pins leave general purpose use");

  a_master_period: assert property (@(posedge clock_in) disable iff (rst_in)
    is_master && gap_valid_reg && $rose(sw_clk) && period_in > PER_W'(1)
      |-> rise_gap_reg == period_in)
    else $error("master switching period off");

endmodule // cspr_pin_routing
`default_nettype wire

/* bench/cspr_partner_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// far-side controller acting as master toward the block under test
module cspr_partner_ctl
#(
  parameter int HALF_NS = 2000
)
(
  input wire logic master_en_in,
  input wire logic [7:0] err_word_in,
  output logic clk_pin_out,
  output logic clk_oe_out,
  output logic [7:0] err_pin_out,
  output logic err_oe_out
);
  // both pins become outputs only while acting as master
  assign clk_oe_out = master_en_in;
  assign err_oe_out = master_en_in;
  // one error word shared by every slave on the link
  assign err_pin_out = err_word_in;
  // switching clock stands still outside master role; the odd offset keeps
  // its edges away from the core clock edges to avoid sampling races
  initial
  begin
    clk_pin_out = 1'b0;
    #37;
    forever
    begin
      if (master_en_in)
      begin
        #(HALF_NS);
        // a role dropped during the half period parks the clock low
        clk_pin_out = master_en_in ? ~clk_pin_out : 1'b0;
      end
      else
      begin
        clk_pin_out = 1'b0;
        #100;
      end
    end
  end
endmodule // cspr_partner_ctl
`default_nettype wire

/* bench/cspr_pin_routing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cspr_pin_routing_tb;
  import cspr_pkg::*;
  // ============================================================
  // stimulus, pins and counters
  typedef struct packed {
    logic [2:0] mode;
    logic sync_oe;
    logic err_oe;
    logic [7:0] err_out;
  } cspr_row_t;
  cspr_row_t rows [8];
  logic clock_in, link_clk_in, rst_in, flt, p_clk, p_clk_oe, p_err_oe;
  logic sync_pin, sync_out, sync_oe, err_oe, sw_clk, locked, p_en;
  logic [2:0] mode, gain;
  logic [15:0] phase, period;
  logic [7:0] amp, p_word, p_err, err_pin, err_out, err_val, reg_err;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n, e;
  // a pin nobody drives shows a pattern that changes every cycle
  assign sync_pin = sync_oe ? sync_out : p_clk_oe ? p_clk : flt;
  assign err_pin = err_oe ? err_out : p_err_oe ? p_err : {8{flt}};
  // far side is master whenever this end is set up as a slave
  // this end keeps its clock pin as an input, gpio drive off
  assign p_en = (mode == CSPR_MODE_MP_SLAVE) || (mode == CSPR_MODE_MO_SLAVE);

  // ============================================================
  // clocks and hang guard
  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #7;
    forever #16 link_clk_in = ~link_clk_in;
  end
  always @(posedge clock_in)
  begin
    flt <= ~flt;
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  cspr_pin_routing DUT (.clock_in(clock_in), .rst_in(rst_in),
    .link_clk_in(link_clk_in), .multiphase_mode_field_in(mode),
    .phase_shift_in(phase), .slave_gain_in(gain), .period_in(period),
    .error_amp_in(amp), .gpio_sync_out_in(1'b1), .gpio_sync_oe_in(1'b0),
    .gpio_err_out_in(8'h5A), .gpio_err_oe_in(1'b1),
    .sync_clock_pin_in(sync_pin), .sync_clock_pin_out(sync_out),
    .sync_clock_pin_oe_out(sync_oe), .error_signal_pin_in(err_pin),
    .error_signal_pin_out(err_out), .error_signal_pin_oe_out(err_oe),
    .error_pin_value_out(err_val), .regulate_error_out(reg_err),
    .sw_clk_out(sw_clk), .locked_out(locked));
  cspr_partner_ctl PARTNER (.master_en_in(p_en), .err_word_in(p_word),
    .clk_pin_out(p_clk), .clk_oe_out(p_clk_oe), .err_pin_out(p_err),
    .err_oe_out(p_err_oe));

  // ============================================================
  // compare and measure helpers
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  // counts taken against an unrelated clock may slip by a sample or two
  task automatic chk_near(input int got, input int exp, input int tol);
    chk_word(16'(got), (got >= exp - tol && got <= exp + tol) ? 16'(got) : 16'(exp));
  endtask
  // core cycles until the next rising edge of the switching clock
  task automatic to_rise(output int cnt);
    cnt = 0;
    while (sw_clk !== 1'b0 && cnt < 200)
    begin
      @(negedge clock_in);
      cnt++;
    end
    while (sw_clk !== 1'b1 && cnt < 200)
    begin
      @(negedge clock_in);
      cnt++;
    end
  endtask
  task automatic chk_reset();
    chk_bit(sync_oe, 1'b0);
    chk_bit(err_oe, 1'b0);
    chk_bit(sw_clk, 1'b0);
    chk_bit(locked, 1'b0);
    chk_word({8'h00, reg_err}, 16'h0000);
  endtask
  // slave lock, followed period and phase offset against the far master
  task automatic slave_test();
    int d0;
    repeat (300) @(negedge clock_in);
    chk_bit(locked, 1'b1);
    to_rise(n);
    to_rise(n);
    chk_near(n, 40, 1);
    @(posedge p_clk);
    to_rise(d0);
    @(posedge clock_in);
    phase <= 16'h000A;
    repeat (100) @(negedge clock_in);
    @(posedge p_clk);
    to_rise(n);
    chk_near(n - d0, 10, 1);
    @(posedge clock_in);
    phase <= 16'h0000;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    rows = '{'{3'h0, 1'b0, 1'b1, 8'h5A}, '{3'h1, 1'b1, 1'b1, 8'hC3},
      '{3'h2, 1'b0, 1'b0, 8'h00}, '{3'h3, 1'b1, 1'b1, 8'h5A},
      '{3'h4, 1'b0, 1'b1, 8'h5A}, '{3'h5, 1'b0, 1'b1, 8'h5A},
      '{3'h6, 1'b0, 1'b1, 8'h5A}, '{3'h7, 1'b0, 1'b1, 8'h5A}};
    rst_in = 1'b1;
    flt = 1'b0;
    mode = 3'h0;
    gain = 3'h0;
    phase = 16'h0000;
    period = 16'h000A;
    amp = 8'hC3;
    p_word = 8'h50;
    repeat (12) @(posedge clock_in);
    #10 chk_reset();
    @(posedge clock_in);
    rst_in <= 1'b0;
    // pin ownership for every mode code
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock_in);
      mode <= rows[i].mode;
      repeat (8) @(negedge clock_in);
      chk_bit(sync_oe, rows[i].sync_oe);
      chk_bit(err_oe, rows[i].err_oe);
      if (rows[i].err_oe)
        chk_word({8'h00, err_out}, {8'h00, rows[i].err_out});
    end
    // both master modes: own period and clock seen on the pin
    for (int m = 1; m < 4; m += 2)
    begin
      @(posedge clock_in);
      mode <= 3'(m);
      repeat (10) @(negedge clock_in);
      to_rise(n);
      to_rise(n);
      chk_word(16'(n), period);
      e = 0;
      for (int k = 0; k < 40; k++)
      begin
        @(negedge clock_in);
        e += int'(sync_out === 1'b1);
      end
      chk_near(e, 20, 2);
    end
    // multi-phase slave, then gain on the incoming error word
    @(posedge clock_in);
    mode <= CSPR_MODE_MP_SLAVE;
    slave_test();
    for (int w = 0; w < 2; w++)
    begin
      for (int g = 0; g < 8; g++)
      begin
        @(posedge clock_in);
        gain <= 3'(g);
        p_word <= w ? 8'hF0 : 8'h50;
        repeat (12) @(negedge clock_in);
        e = ((w ? 240 : 80) * (8 + g)) >>> 3;
        e = (e > 255) ? 255 : e;
        chk_word({8'h00, err_val}, {8'h00, p_word});
        chk_word({8'h00, reg_err}, 16'(e));
      end
    end
    // multiple-output slave follows the far clock as well
    @(posedge clock_in);
    mode <= CSPR_MODE_MO_SLAVE;
    slave_test();
    // second reset in mid-run
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (12) @(negedge clock_in);
    chk_reset();
    test_done();
  end
endmodule // cspr_pin_routing_tb
`default_nettype wire
